// >>> pkg/peci_pkg.sv
package peci_pkg;

  // Pin count and register data width of the change detector.
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets on the APB.
  localparam logic [11:0] OFF_RISE_EN = 12'h000;
  localparam logic [11:0] OFF_FALL_EN = 12'h004;
  localparam logic [11:0] OFF_FLAGS = 12'h008;
  localparam logic [11:0] OFF_CTRL = 12'h00C;
  localparam logic [11:0] OFF_SUMMARY = 12'h010;
  localparam logic [11:0] OFF_INT_STAT = 12'h014;
  localparam logic [11:0] OFF_INT_CLR = 12'h018;
  localparam logic [11:0] OFF_INT_EN = 12'h01C;

  // Field positions.
  localparam int unsigned CTRL_MASTER_EN_BIT = 0;
  localparam int unsigned SUMMARY_FLAG_BIT = 0;
  localparam int unsigned EV_EDGE_BIT = 0;
  localparam int unsigned EV_COLLIDE_BIT = 1;
  localparam int unsigned EV_COUNT = 2;

  // Reset values.
  localparam logic [5:0] PIN_RESET = 6'h00;
  localparam logic [1:0] EV_RESET = 2'h0;
  localparam logic CTRL_RESET = 1'b0;

  // Pins usable with the debugger off, and while it holds the two lowest positions.
  localparam logic [5:0] PIN_MASK_ALL = 6'h3F;
  localparam logic [5:0] PIN_MASK_DEBUG = 6'h3C;

  // Per-pin edge pulses.
  typedef struct packed {
    logic [5:0] rise;
    logic [5:0] fall;
  } peci_edge_t;

  // Software-visible configuration of the detector.
  typedef struct packed {
    logic [5:0] rise_en;
    logic [5:0] fall_en;
    logic master_en;
  } peci_cfg_t;

endpackage

// >>> hdl/peci_edge_detect.sv
`timescale 1ns/1ps

module peci_edge_detect
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] pin_raw,
  output peci_pkg::peci_edge_t edges
);

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_pin
      // Each pin keeps its own flops, so no vector is written by
      // several processes.
      logic meta_q;
      logic sync_q;
      logic prev_q;

      // Two flops tame the asynchronous pin, a third holds the old sample.
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end
        else
        begin
          meta_q <= pin_raw[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end

      assign edges.rise[i] = sync_q & ~prev_q;
      assign edges.fall[i] = ~sync_q & prev_q;
    end
  endgenerate

endmodule // peci_edge_detect

// >>> hdl/peci_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Rising edges count on a pin only while its rise enable is set.
// - Falling edges count on a pin only while its fall enable is set.
// - Both enables set means edges of either direction are detected.
// - An enabled edge sets the pin flag; change_irq follows master enable.
// - With master enable clear, flags still set but no change_irq or wake.
// - Summary flag is one whenever any pin flag is one.
// - Software writing zero to a flag bit clears that flag.
// - An edge during a flag write leaves the flag set.
// - An enabled edge event wakes the device when master enable set.
// - Enable and flag registers use bits five to zero; rest read zero.
// - All enable and flag bits reset to zero.
// - Flag one means enabled change seen; zero means none or cleared. A software write of one also sets the flag.
// - With debugger enabled, pin positions one and zero are unusable.
module peci_top
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] port_a_pin,
  input wire logic debug_en,
  output logic change_summary_flag,
  output logic change_irq,
  output logic wake_req,
  output logic irq
);

  // Configuration and state registers.
  peci_pkg::peci_cfg_t cfg_q;
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic summary_q;
  logic change_irq_q;
  logic wake_q;
  logic [1:0] int_stat_q;
  logic [1:0] int_stat_d;
  logic [1:0] int_en_q;
  logic irq_q;

  // Bus slave registers.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Debug strap synchroniser.
  logic dbg_meta_q;
  logic dbg_sync_q;

  // Combinational helpers.
  peci_pkg::peci_edge_t edges;
  logic [5:0] pin_mask;
  logic [5:0] edge_set;
  logic bus_setup;
  logic bus_done;
  logic wr_done;
  logic addr_hit;
  logic [31:0] rd_value;
  logic flag_wr;
  logic int_clr_wr;
  logic [1:0] events;
  logic rise_wr;
  logic fall_wr;
  logic ctrl_wr;
  logic int_en_wr;

  // Per-pin synchronisers and edge pulses.
  peci_edge_detect u_edge
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_raw(port_a_pin),
    .edges(edges)
  );

  // The debugger flag comes from outside this clock, so it is
  // synchronised before it masks anything.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dbg_meta_q <= 1'b0;
      dbg_sync_q <= 1'b0;
    end
    else
    begin
      dbg_meta_q <= debug_en;
      dbg_sync_q <= dbg_meta_q;
    end
  end

  assign pin_mask = dbg_sync_q ? peci_pkg::PIN_MASK_DEBUG
                               : peci_pkg::PIN_MASK_ALL;

  // Each direction is gated by its own enable; with both set, both
  // directions pass, which is just the OR of the two terms.
  // rise gating.
  assign edge_set = ((edges.rise & cfg_q.rise_en) |
                     (edges.fall & cfg_q.fall_en)) & pin_mask;

  // APB phase decode; the slave answers with one registered pready.
  assign bus_setup = psel & ~penable;
  assign bus_done = psel & penable & pready_q;
  assign wr_done = bus_done & pwrite;
  assign flag_wr = wr_done & (paddr == peci_pkg::OFF_FLAGS);
  assign int_clr_wr = wr_done & (paddr == peci_pkg::OFF_INT_CLR);

  // Per-register write strobes; each lands at the edge that samples
  // pready, so a register never sees a half-finished transfer.
  assign rise_wr = wr_done & (paddr == peci_pkg::OFF_RISE_EN);
  assign fall_wr = wr_done & (paddr == peci_pkg::OFF_FALL_EN);
  assign ctrl_wr = wr_done & (paddr == peci_pkg::OFF_CTRL);
  assign int_en_wr = wr_done & (paddr == peci_pkg::OFF_INT_EN);

  // Address decode and read mux; unused bits read as zero.
  // upper bits zero.
  always_comb
  begin
    addr_hit = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (paddr)
      peci_pkg::OFF_RISE_EN:
        rd_value[5:0] = cfg_q.rise_en;
      peci_pkg::OFF_FALL_EN:
        rd_value[5:0] = cfg_q.fall_en;
      peci_pkg::OFF_FLAGS:
        rd_value[5:0] = flags_q;
      peci_pkg::OFF_CTRL:
        rd_value[peci_pkg::CTRL_MASTER_EN_BIT] = cfg_q.master_en;
      peci_pkg::OFF_SUMMARY:
        rd_value[peci_pkg::SUMMARY_FLAG_BIT] = summary_q;
      peci_pkg::OFF_INT_STAT:
        rd_value[1:0] = int_stat_q;
      peci_pkg::OFF_INT_CLR:
        rd_value = 32'h0000_0000;
      peci_pkg::OFF_INT_EN:
        rd_value[1:0] = int_en_q;
      default:
        addr_hit = 1'b0;
    endcase
  end

  // Bus answer: pready rises in the access phase one edge after setup,
  // so every transfer has zero wait states and data from a flop.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (bus_setup)
    begin
      pready_q <= 1'b1;
      pslverr_q <= ~addr_hit;
      prdata_q <= (pwrite || !addr_hit) ? 32'h0000_0000 : rd_value;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // Enable and control registers; bits held by the debugger stay zero.
  // reset to zero.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_q.rise_en <= peci_pkg::PIN_RESET;
      cfg_q.fall_en <= peci_pkg::PIN_RESET;
      cfg_q.master_en <= peci_pkg::CTRL_RESET;
    end
    else
    begin
      if (rise_wr)
      begin
        cfg_q.rise_en <= pwdata[5:0] & pin_mask;
      end
      else
      begin
        cfg_q.rise_en <= cfg_q.rise_en & pin_mask;
      end
      if (fall_wr)
      begin
        cfg_q.fall_en <= pwdata[5:0] & pin_mask;
      end
      else
      begin
        cfg_q.fall_en <= cfg_q.fall_en & pin_mask;
      end
      if (ctrl_wr)
      begin
        cfg_q.master_en <= pwdata[peci_pkg::CTRL_MASTER_EN_BIT];
      end
    end
  end

  // Flag next value. A write replaces the stored bits, so zero clears
  // and one sets; an edge in the same cycle is ORed on top and wins.
  // Software that writes back stale ones would re-set flags, hence the
  // advice to clear only by masking bits already seen.
  // zero clears flag.
  always_comb
  begin
    flags_d = flags_q;
    if (flag_wr)
    begin
      flags_d = pwdata[5:0];
    end
    flags_d = (flags_d | edge_set) & pin_mask;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags_q <= peci_pkg::PIN_RESET;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // Summary and interrupt follow the next flag value, so they line up
  // with the flag register in the same cycle.
  // summary of flags.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      summary_q <= 1'b0;
      change_irq_q <= 1'b0;
    end
    else
    begin
      summary_q <= |flags_d;
      change_irq_q <= (|flags_d) & cfg_q.master_en;
    end
  end

  // Wake is a one-cycle pulse per newly detected enabled edge, even
  // while the flag is already set, because sleep may have begun since.
  // wake on edge.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= (|edge_set) & cfg_q.master_en;
    end
  end

  // Sticky events: any enabled edge, and an edge that met a flag write.
  assign events[peci_pkg::EV_EDGE_BIT] = |edge_set;
  assign events[peci_pkg::EV_COLLIDE_BIT] = flag_wr & (|edge_set);

  // A set in the clear cycle survives.
  always_comb
  begin
    int_stat_d = int_stat_q;
    if (int_clr_wr)
    begin
      int_stat_d = int_stat_q & ~pwdata[1:0];
    end
    int_stat_d = int_stat_d | events;
  end

  // Sticky status register. Clear and set meet in one cycle only when
  // software clears while an event arrives; the event must not be lost,
  // so the set is applied after the clear.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_stat_q <= peci_pkg::EV_RESET;
    end
    else
    begin
      int_stat_q <= int_stat_d;
    end
  end

  // Interrupt enable register, same layout as the status register.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_en_q <= peci_pkg::EV_RESET;
    end
    else if (int_en_wr)
    begin
      int_en_q <= pwdata[1:0];
    end
  end

  // Level interrupt. It is built from the next status and enable values
  // so that it changes at the same edge as the registers it summarises;
  // the cost is a deeper cone of logic in front of the flop.
  // level interrupt.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_q <= 1'b0;
    end
    else if (int_en_wr)
    begin
      irq_q <= |(int_stat_d & pwdata[1:0]);
    end
    else
    begin
      irq_q <= |(int_stat_d & int_en_q);
    end
  end

  // Outputs straight from flops.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign change_summary_flag = summary_q;
  assign change_irq = change_irq_q;
  assign wake_req = wake_q;
  assign irq = irq_q;

endmodule // peci_top

// >>> tb/peci_monitor.sv
`timescale 1ns/1ps

// Port-level checks of the change detector.
module peci_monitor
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] port_a_pin,
  input wire logic change_summary_flag,
  input wire logic change_irq,
  input wire logic wake_req
);
  logic wr_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // A write lands one edge before its effect is visible, so remember it.
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      wr_q <= 1'b0;
    else
      wr_q <= psel && penable && pwrite;

  // Long enough that no pin edge is still in the synchroniser.
  sequence pins_quiet;
    $stable(port_a_pin)[*5];
  endsequence

  sequence flag_wipe;
    psel && penable && pready && pwrite && paddr == peci_pkg::OFF_FLAGS
      && pwdata[5:0] == 6'h00;
  endsequence

  AST_SETUP_ANSWER:
  assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_ONE:
  assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY:
  assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_IDLE_DATA:
  assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_QUIET:
  assert property (pins_quiet ##0 !wr_q |-> !$rose(change_summary_flag))
    else $error("flag rose with no pin change");
  AST_CLEAR:
  assert property (pins_quiet ##0 flag_wipe |=> !change_summary_flag)
    else $error("flags not cleared by zero write");
  AST_IRQ:
  assert property (change_irq |-> change_summary_flag)
    else $error("interrupt without flag");
  AST_WAKE:
  assert property (wake_req |-> change_irq)
    else $error("wake without enabled interrupt");
endmodule // peci_monitor

// >>> tb/test_pin_edge_change_interrupt.sv
`timescale 1ns/1ps

// Self-checking bench for the change detector.
module test_pin_edge_change_interrupt;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] pins = 6'h00;
  logic debug_en = 1'b0;
  logic sum_flag;
  logic change_irq;
  logic wake_req;
  logic irq;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_checks = 0;
  int wake_cnt = 0;
  int w0 = 0;
  // Rise enable, fall enable, pins before, pins after, expected flags.
  logic [5:0] tab [6][5] = '{
    '{6'h3F, 6'h00, 6'h00, 6'h3F, 6'h3F},
    '{6'h3F, 6'h00, 6'h3F, 6'h00, 6'h00},
    '{6'h00, 6'h3F, 6'h3F, 6'h00, 6'h3F},
    '{6'h00, 6'h3F, 6'h00, 6'h3F, 6'h00},
    '{6'h05, 6'h0A, 6'h00, 6'h0F, 6'h05},
    '{6'h3C, 6'h3C, 6'h0C, 6'h30, 6'h3C}};

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  // Wake pulses last one cycle, so they are counted as they pass.
  always @(posedge ref_clk)
    if (wake_req === 1'b1)
      wake_cnt <= wake_cnt + 1;

  peci_top dut_u
  (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_pin(pins), .debug_en(debug_en),
    .change_summary_flag(sum_flag), .change_irq(change_irq),
    .wake_req(wake_req), .irq(irq)
  );

  task stop_test;
    $display("checks %0d wrong %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Main sequence: table rows first, then the awkward cases.
  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    apb(1'b1, peci_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, peci_pkg::OFF_INT_EN, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      pins <= tab[i][2];
      repeat (8) @(posedge ref_clk);
      apb(1'b1, peci_pkg::OFF_RISE_EN, {26'h0, tab[i][0]});
      apb(1'b1, peci_pkg::OFF_FALL_EN, {26'h0, tab[i][1]});
      apb(1'b1, peci_pkg::OFF_FLAGS, 32'h0);
      w0 = wake_cnt;
      pins <= tab[i][3];
      repeat (8) @(posedge ref_clk);
      apb(1'b0, peci_pkg::OFF_FLAGS, 32'h0);
      chk(rd, {26'h0, tab[i][4]});
      chk({31'h0, sum_flag}, {31'h0, |tab[i][4]});
      chk({31'h0, change_irq}, {31'h0, |tab[i][4]});
      chk(32'(wake_cnt - w0), {31'h0, |tab[i][4]});
      $display("row %0d done", i);
    end
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, peci_pkg::OFF_INT_EN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, peci_pkg::OFF_INT_CLR, 32'h3);
    apb(1'b1, peci_pkg::OFF_INT_EN, 32'h1);
    apb(1'b0, peci_pkg::OFF_INT_STAT, 32'h0);
    chk(rd | {31'h0, irq}, 32'h0);
    apb(1'b1, peci_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, peci_pkg::OFF_FLAGS, 32'h0);
    w0 = wake_cnt;
    pins <= 6'h0F;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, peci_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h3C);
    chk({30'h0, sum_flag, change_irq}, 32'h2);
    chk(32'(wake_cnt - w0), 32'h0);
    apb(1'b1, peci_pkg::OFF_FLAGS, rd & ~32'h0000_000C);
    apb(1'b0, peci_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h30);
    $display("master off done");
    pins <= 6'h00;
    repeat (8) @(posedge ref_clk);
    apb(1'b1, peci_pkg::OFF_FLAGS, 32'h0);
    // The pin edge lands on or after the edge of the clearing write.
    for (int d = 0; d < 2; d++)
    begin
      pins <= pins ^ 6'h04;
      if (d == 1)
        @(posedge ref_clk);
      apb(1'b1, peci_pkg::OFF_FLAGS, 32'h0);
      repeat (8) @(posedge ref_clk);
      apb(1'b0, peci_pkg::OFF_FLAGS, 32'h0);
      chk(rd, 32'h4);
      apb(1'b1, peci_pkg::OFF_FLAGS, 32'h0);
    end
    apb(1'b0, peci_pkg::OFF_INT_STAT, 32'h0);
    chk(rd, 32'h3);
    $display("collision done");
    debug_en <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(1'b1, peci_pkg::OFF_RISE_EN, 32'hFFFFFFFF);
    apb(1'b0, peci_pkg::OFF_RISE_EN, 32'h0);
    chk(rd, 32'h3C);
    pins <= 6'h3F;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, peci_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h3C);
    debug_en <= 1'b0;
    repeat (8) @(posedge ref_clk);
    apb(1'b1, peci_pkg::OFF_RISE_EN, 32'hFFFFFFFF);
    apb(1'b0, peci_pkg::OFF_RISE_EN, 32'h0);
    chk(rd, 32'h3F);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("debug and map done");
    pins <= 6'h00;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (int a = 0; a < 8; a++)
    begin
      apb(1'b0, 12'(a * 4), 32'h0);
      chk(rd | {31'h0, sum_flag}, 32'h0);
    end
    $display("reset done");
    stop_test();
  end
endmodule // test_pin_edge_change_interrupt

bind peci_top peci_monitor mon_u
(
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_a_pin(port_a_pin),
  .change_summary_flag(change_summary_flag), .change_irq(change_irq),
  .wake_req(wake_req)
);
